// ===== alu_defines.vh
`ifndef ALU_DEFINES_VH
`define ALU_DEFINES_VH
// ---------------------------------------------------------------
// operation codes
// ---------------------------------------------------------------
`define OP_W 5
`define OP_SUM 5'h00
`define OP_DIFF 5'h01
`define OP_SUM_WITH_CARRY 5'h02
`define OP_DIFFERENCE_WITH_BORROW 5'h03
`define OP_PLUS_ONE 5'h04
`define OP_MINUS_ONE 5'h05
`define OP_WORD_SMALL_SUM 5'h06
`define OP_WORD_SMALL_DIFFERENCE 5'h07
`define OP_DECIMAL_FIX_AFTER_SUM 5'h08
`define OP_DECIMAL_FIX_AFTER_DIFFERENCE 5'h09
`define OP_UNSIGNED_MULTIPLY 5'h0a
`define OP_UNSIGNED_DIVIDE 5'h0b
`define OP_COMPARE 5'h0c
`define OP_ARITH_COMPLEMENT 5'h0d
`define OP_AND 5'h0e
`define OP_OR 5'h0f
`define OP_XOR 5'h10
`define OP_NOT 5'h11
`define OP_ARITH_LEFT_SHIFT 5'h12
`define OP_ARITH_RIGHT_SHIFT 5'h13
`define OP_LOGIC_LEFT_SHIFT 5'h14
`define OP_LOGIC_RIGHT_SHIFT 5'h15
`define OP_ROTATE_LEFT 5'h16
`define OP_ROTATE_RIGHT 5'h17
`define OP_ROTATE_LEFT_VIA_CARRY 5'h18
`define OP_ROTATE_RIGHT_VIA_CARRY 5'h19
// ---------------------------------------------------------------
// flag positions inside condition_flags
// ---------------------------------------------------------------
`define FLAG_C 0
`define FLAG_V 1
`define FLAG_Z 2
`define FLAG_N 3
`define FLAGS_RESET 4'h0
// ---------------------------------------------------------------
// widths and constants
// ---------------------------------------------------------------
`define BYTE_MSB 7
`define WORD_MSB 15
`define DIV_STEPS 8
`define STEP_ONE 16'h0001
`define STEP_TWO 16'h0002
`define DIGIT_FIX_LO 8'h06
`define DIGIT_FIX_HI 8'h60
`define DIGIT_MAX 4'h9
`define BYTE_MAX 8'h99
`endif

// ===== decimal_fix.v
`include "alu_defines.vh"
// decimal correction of a byte after a sum or a difference
module decimal_fix (
  // operand and flags
  input wire [7:0] value_i,
  input wire carry_i,
  input wire half_i,
  input wire after_diff_i,
  // corrected result
  output reg [7:0] result_o,
  output reg carry_o
);
  reg [7:0] fix; // correction amount
  // ---------------------------------------------------------------
  // correction choice from flags and digits
  // ---------------------------------------------------------------
  always @* begin
    fix = 8'h00;
    carry_o = carry_i;
    if (half_i || (!after_diff_i && value_i[3:0] > `DIGIT_MAX)) begin
      fix = fix | `DIGIT_FIX_LO;
    end
    if (carry_i || (!after_diff_i && value_i > `BYTE_MAX)) begin
      fix = fix | `DIGIT_FIX_HI;
      carry_o = 1'b1;
    end
    // a difference subtracts the correction, a sum adds it
    if (after_diff_i) begin
      result_o = value_i - fix;
    end else begin
      result_o = value_i + fix;
    end
  end
endmodule

// ===== serial_divider.v
`include "alu_defines.vh"
// restoring divider: 16-bit dividend by 8-bit divisor, one bit a cycle
module serial_divider #(
  parameter STEPS = `DIV_STEPS
) (
  // clock, reset, enable
  input wire clk_i,
  input wire rst_i,
  input wire ce_i,
  // request
  input wire start_i,
  input wire [15:0] dividend_i,
  input wire [7:0] divisor_i,
  // answer
  output wire busy_o,
  output reg done_o,
  output reg [7:0] quotient_o,
  output reg [7:0] remainder_o
);
  reg [7:0] rem_q; // partial remainder, below the divisor when the loaded high byte is below it
  reg [7:0] quo_q; // quotient bits shifted in
  reg [3:0] count_q; // steps left
  reg [7:0] dvs_q; // latched divisor
  wire [8:0] trial; // remainder shifted by one
  wire fits; // divisor fits in trial
  assign trial = {rem_q[7:0], quo_q[7]};
  assign fits = trial >= {1'b0, dvs_q};
  assign busy_o = (count_q != 4'h0);
  // ---------------------------------------------------------------
  // division sequence
  // ---------------------------------------------------------------
  always @(posedge clk_i) begin
    if (rst_i) begin
      rem_q <= 8'h00;
      quo_q <= 8'h00;
      count_q <= 4'h0;
      dvs_q <= 8'h00;
      done_o <= 1'b0;
      quotient_o <= 8'h00;
      remainder_o <= 8'h00;
    end else if (ce_i) begin
      done_o <= 1'b0;
      if (start_i && !busy_o) begin
        // load high byte as remainder, low byte as quotient shifter
        rem_q <= dividend_i[15:8];
        quo_q <= dividend_i[7:0];
        dvs_q <= divisor_i;
        count_q <= STEPS[3:0];
      end else if (busy_o) begin
        // shift and subtract when the divisor fits
        if (fits) begin
          rem_q <= trial[7:0] - dvs_q;
        end else begin
          rem_q <= trial[7:0];
        end
        quo_q <= {quo_q[6:0], fits};
        count_q <= count_q - 4'h1;
        if (count_q == 4'h1) begin
          done_o <= 1'b1;
          quotient_o <= {quo_q[6:0], fits};
          if (fits) begin
            remainder_o <= trial[7:0] - dvs_q;
          end else begin
            remainder_o <= trial[7:0];
          end
        end
      end
    end
  end
endmodule

// ===== cpu_arith_logic_shift_unit.v
// What this block does
// - sum/difference: byte or word, register results
// - no immediate form of plain difference
// - word sum/difference only register with register
// - carry forms: byte, add/subtract carry flag
// - plus/minus one on a byte register
// - word small steps: immediate 1 or 2
// - decimal fix to packed BCD using flags
// - 8x8 unsigned multiply, 16-bit product
// - 16/8 unsigned divide, quotient and remainder
// - compare updates flags only
// - word compare only register with register
// - arithmetic complement: zero minus value
// - and, or, xor with register/immediate
// - ones complement of a byte register
// - arithmetic shifts; right keeps sign
// - logical shifts fill with zero
// - rotate: out bit enters other end
// - rotate via carry through carry flag
// - flag register holds N, Z, V, C
`include "alu_defines.vh"
module cpu_arith_logic_shift_unit #(
  parameter DIV_STEPS = `DIV_STEPS
) (
  // clock, reset, enable
  input wire CLOCK_I,
  input wire RST_I,
  input wire CE_I,
  // request from the decoder
  input wire START_I,
  input wire [4:0] OP_I,
  input wire WORD_I,
  input wire IMM_I,
  input wire [15:0] DEST_I,
  input wire [15:0] SOURCE_REGISTER_I,
  input wire [15:0] IMM_DATA_I,
  // answer to the register file
  output wire BUSY_O,
  output reg DONE_O,
  output reg WRITE_O,
  output reg WORD_O,
  output reg ILLEGAL_O,
  output reg [15:0] RESULT_O,
  // condition flags
  output wire [3:0] CONDITION_FLAGS_O
);
  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  reg [3:0] condition_flags_q; // N Z V C
  reg half_q; // half carry of the last byte sum or difference
  reg div_pend_q; // a divide is running
  // ---------------------------------------------------------------
  // combinational result
  // ---------------------------------------------------------------
  reg [15:0] res_d; // result value
  reg [3:0] flags_d; // next flags
  reg half_d; // next half carry
  reg write_d; // result goes to destination
  reg illegal_d; // form not supported
  reg [15:0] opb; // second operand
  reg [16:0] wide; // sum with carry out
  reg sub; // difference when high
  reg cin; // carry in
  reg word; // width of this operation
  reg out_bit; // bit leaving a shift
  reg arith; // adder in use; updates N, Z, V and C, but plus/minus one keep C
  wire [7:0] fix_value; // decimal fix output
  wire fix_carry; // decimal fix carry
  wire div_busy; // divider running
  wire div_done; // divider answer pulse
  wire [7:0] quotient; // divider quotient
  wire [7:0] remainder; // divider remainder
  wire c_in_flag; // current carry flag
  assign c_in_flag = condition_flags_q[`FLAG_C];
  assign CONDITION_FLAGS_O = condition_flags_q;
  assign BUSY_O = div_busy | div_pend_q;
  // zero test at the given width
  function is_zero;
    input [15:0] v;
    input w;
    begin
      if (w) begin
        is_zero = (v == 16'h0000);
      end else begin
        is_zero = (v[7:0] == 8'h00);
      end
    end
  endfunction
  // sign bit at the given width
  function sign_of;
    input [15:0] v;
    input w;
    begin
      if (w) begin
        sign_of = v[`WORD_MSB];
      end else begin
        sign_of = v[`BYTE_MSB];
      end
    end
  endfunction
  // ---------------------------------------------------------------
  // decimal fix and divider
  // ---------------------------------------------------------------
  decimal_fix u_fix (
    .value_i(DEST_I[7:0]),
    .carry_i(c_in_flag),
    .half_i(half_q),
    .after_diff_i(OP_I == `OP_DECIMAL_FIX_AFTER_DIFFERENCE),
    .result_o(fix_value),
    .carry_o(fix_carry)
  );
  serial_divider #(
    .STEPS(DIV_STEPS)
  ) u_div (
    .clk_i(CLOCK_I),
    .rst_i(RST_I),
    .ce_i(CE_I),
    .start_i(START_I && !BUSY_O && OP_I == `OP_UNSIGNED_DIVIDE),
    .dividend_i(DEST_I),
    .divisor_i(SOURCE_REGISTER_I[7:0]),
    .busy_o(div_busy),
    .done_o(div_done),
    .quotient_o(quotient),
    .remainder_o(remainder)
  );
  // ---------------------------------------------------------------
  // operation decode and compute
  // ---------------------------------------------------------------
  always @* begin
    res_d = DEST_I;
    flags_d = condition_flags_q;
    half_d = half_q;
    write_d = 1'b1;
    illegal_d = 1'b0;
    opb = IMM_I ? IMM_DATA_I : SOURCE_REGISTER_I;
    sub = 1'b0;
    cin = 1'b0;
    word = 1'b0;
    out_bit = 1'b0;
    arith = 1'b0;
    wide = 17'h00000;
    case (OP_I)
      `OP_SUM: begin
        word = WORD_I;
        arith = 1'b1;
        if (WORD_I && IMM_I) begin
          illegal_d = 1'b1;
        end
      end
      `OP_DIFF: begin
        word = WORD_I;
        sub = 1'b1;
        arith = 1'b1;
        if (IMM_I) begin
          illegal_d = 1'b1;
        end
      end
      `OP_SUM_WITH_CARRY: begin
        cin = c_in_flag;
        arith = 1'b1;
      end
      `OP_DIFFERENCE_WITH_BORROW: begin
        sub = 1'b1;
        cin = c_in_flag;
        arith = 1'b1;
      end
      `OP_PLUS_ONE: begin
        opb = `STEP_ONE;
        arith = 1'b1;
      end
      `OP_MINUS_ONE: begin
        opb = `STEP_ONE;
        sub = 1'b1;
        arith = 1'b1;
      end
      `OP_WORD_SMALL_SUM, `OP_WORD_SMALL_DIFFERENCE: begin
        // flags stay; only steps of one or two are legal
        if (IMM_DATA_I != `STEP_ONE && IMM_DATA_I != `STEP_TWO) begin
          illegal_d = 1'b1;
        end
        if (OP_I == `OP_WORD_SMALL_SUM) begin
          res_d = DEST_I + IMM_DATA_I;
        end else begin
          res_d = DEST_I - IMM_DATA_I;
        end
      end
      `OP_DECIMAL_FIX_AFTER_SUM, `OP_DECIMAL_FIX_AFTER_DIFFERENCE: begin
        res_d = {DEST_I[15:8], fix_value};
        flags_d[`FLAG_C] = fix_carry;
        flags_d[`FLAG_Z] = is_zero({8'h00, fix_value}, 1'b0);
        flags_d[`FLAG_N] = fix_value[`BYTE_MSB];
      end
      `OP_UNSIGNED_MULTIPLY: begin
        res_d = DEST_I[7:0] * SOURCE_REGISTER_I[7:0];
      end
      `OP_UNSIGNED_DIVIDE: begin
        write_d = 1'b0; // answer comes from the divider
      end
      `OP_COMPARE: begin
        word = WORD_I;
        sub = 1'b1;
        arith = 1'b1;
        write_d = 1'b0;
        if (WORD_I && IMM_I) begin
          illegal_d = 1'b1;
        end
      end
      `OP_ARITH_COMPLEMENT: begin
        opb = DEST_I;
        sub = 1'b1;
        arith = 1'b1;
      end
      `OP_AND: res_d = {DEST_I[15:8], DEST_I[7:0] & opb[7:0]};
      `OP_OR: res_d = {DEST_I[15:8], DEST_I[7:0] | opb[7:0]};
      `OP_XOR: res_d = {DEST_I[15:8], DEST_I[7:0] ^ opb[7:0]};
      `OP_NOT: res_d = {DEST_I[15:8], ~DEST_I[7:0]};
      `OP_ARITH_LEFT_SHIFT, `OP_LOGIC_LEFT_SHIFT: begin
        out_bit = DEST_I[7];
        res_d = {DEST_I[15:8], DEST_I[6:0], 1'b0};
      end
      `OP_ARITH_RIGHT_SHIFT: begin
        out_bit = DEST_I[0];
        res_d = {DEST_I[15:8], DEST_I[7], DEST_I[7:1]};
      end
      `OP_LOGIC_RIGHT_SHIFT: begin
        out_bit = DEST_I[0];
        res_d = {DEST_I[15:8], 1'b0, DEST_I[7:1]};
      end
      `OP_ROTATE_LEFT: begin
        out_bit = DEST_I[7];
        res_d = {DEST_I[15:8], DEST_I[6:0], DEST_I[7]};
      end
      `OP_ROTATE_RIGHT: begin
        out_bit = DEST_I[0];
        res_d = {DEST_I[15:8], DEST_I[0], DEST_I[7:1]};
      end
      `OP_ROTATE_LEFT_VIA_CARRY: begin
        out_bit = DEST_I[7];
        res_d = {DEST_I[15:8], DEST_I[6:0], c_in_flag};
      end
      `OP_ROTATE_RIGHT_VIA_CARRY: begin
        out_bit = DEST_I[0];
        res_d = {DEST_I[15:8], c_in_flag, DEST_I[7:1]};
      end
      default: begin
        write_d = 1'b0;
        illegal_d = 1'b1;
      end
    endcase
    // adder shared by the arithmetic family
    if (arith) begin
      if (OP_I == `OP_ARITH_COMPLEMENT) begin
        wide = {1'b0, 16'h0000} - {9'h000, DEST_I[7:0]};
      end else if (sub) begin
        wide = {1'b0, DEST_I} - {1'b0, opb} - {16'h0000, cin};
      end else begin
        wide = {1'b0, DEST_I} + {1'b0, opb} + {16'h0000, cin};
      end
      if (word) begin
        res_d = wide[15:0];
        flags_d[`FLAG_C] = wide[16];
        flags_d[`FLAG_V] = sub ?
          (DEST_I[15] ^ opb[15]) & (DEST_I[15] ^ wide[15]) :
          ~(DEST_I[15] ^ opb[15]) & (DEST_I[15] ^ wide[15]);
      end else begin
        res_d = {DEST_I[15:8], wide[7:0]};
        flags_d[`FLAG_C] = wide[8] ^ DEST_I[8] ^ opb[8];
        if (OP_I == `OP_ARITH_COMPLEMENT) begin
          flags_d[`FLAG_V] = (DEST_I[7:0] == 8'h80);
          flags_d[`FLAG_C] = (DEST_I[7:0] != 8'h00);
        end else begin
          flags_d[`FLAG_V] = sub ?
            (DEST_I[7] ^ opb[7]) & (DEST_I[7] ^ wide[7]) :
            ~(DEST_I[7] ^ opb[7]) & (DEST_I[7] ^ wide[7]);
        end
        half_d = wide[4] ^ DEST_I[4] ^ opb[4];
      end
      // plus and minus one leave carry alone
      if (OP_I == `OP_PLUS_ONE || OP_I == `OP_MINUS_ONE) begin
        flags_d[`FLAG_C] = c_in_flag;
      end
      flags_d[`FLAG_Z] = is_zero(wide[15:0], word);
      flags_d[`FLAG_N] = sign_of(wide[15:0], word);
    end
    // logic results update N and Z and clear V
    if (OP_I >= `OP_AND && OP_I <= `OP_NOT) begin
      flags_d[`FLAG_Z] = is_zero(res_d, 1'b0);
      flags_d[`FLAG_N] = sign_of(res_d, 1'b0);
      flags_d[`FLAG_V] = 1'b0;
    end
    // shifts and rotates
    if (OP_I >= `OP_ARITH_LEFT_SHIFT) begin
      flags_d[`FLAG_C] = out_bit;
      flags_d[`FLAG_Z] = is_zero(res_d, 1'b0);
      flags_d[`FLAG_N] = sign_of(res_d, 1'b0);
      flags_d[`FLAG_V] = (OP_I == `OP_ARITH_LEFT_SHIFT) ?
        (DEST_I[7] ^ DEST_I[6]) : 1'b0;
    end
    // refused forms change nothing
    if (illegal_d) begin
      write_d = 1'b0;
      flags_d = condition_flags_q;
      half_d = half_q;
    end
  end
  // ---------------------------------------------------------------
  // registered answer and flag register
  // ---------------------------------------------------------------
  always @(posedge CLOCK_I) begin
    if (RST_I) begin
      condition_flags_q <= `FLAGS_RESET;
      half_q <= 1'b0;
      div_pend_q <= 1'b0;
      DONE_O <= 1'b0;
      WRITE_O <= 1'b0;
      WORD_O <= 1'b0;
      ILLEGAL_O <= 1'b0;
      RESULT_O <= 16'h0000;
    end else if (CE_I) begin
      DONE_O <= 1'b0;
      WRITE_O <= 1'b0;
      ILLEGAL_O <= 1'b0;
      if (div_done) begin
        // remainder high, quotient low
        div_pend_q <= 1'b0;
        DONE_O <= 1'b1;
        WRITE_O <= 1'b1;
        WORD_O <= 1'b1;
        RESULT_O <= {remainder, quotient};
        condition_flags_q[`FLAG_Z] <= (quotient == 8'h00);
        condition_flags_q[`FLAG_N] <= quotient[`BYTE_MSB];
      end else if (START_I && !BUSY_O) begin
        if (OP_I == `OP_UNSIGNED_DIVIDE) begin
          div_pend_q <= 1'b1;
        end else begin
          DONE_O <= 1'b1;
          WRITE_O <= write_d;
          ILLEGAL_O <= illegal_d;
          WORD_O <= word || OP_I == `OP_UNSIGNED_MULTIPLY ||
            OP_I == `OP_WORD_SMALL_SUM ||
            OP_I == `OP_WORD_SMALL_DIFFERENCE;
          RESULT_O <= res_d;
          condition_flags_q <= flags_d;
          half_q <= half_d;
        end
      end
    end
  end
endmodule

// ===== alu_checker_assertions.sv
`include "alu_defines.vh"
// watches the unit's ports only
module alu_checker #(
  parameter DIV_STEPS = 8
) (
  // clock and reset
  input wire logic CLOCK_I,
  input wire logic RST_I,
  // request
  input wire logic CE_I,
  input wire logic START_I,
  input wire logic [4:0] OP_I,
  input wire logic WORD_I,
  input wire logic IMM_I,
  input wire logic [15:0] DEST_I,
  input wire logic [15:0] SOURCE_REGISTER_I,
  input wire logic [15:0] IMM_DATA_I,
  // answer
  input wire logic BUSY_O,
  input wire logic DONE_O,
  input wire logic WRITE_O,
  input wire logic ILLEGAL_O,
  input wire logic [15:0] RESULT_O,
  input wire logic [3:0] CONDITION_FLAGS_O
);
  timeunit 1ns;
  timeprecision 1ps;
  // ---------------------------------------------
  // helper logic
  // ---------------------------------------------
  logic [7:0] d_q;  // destination byte of the last cycle
  logic [7:0] s_q;  // source byte of the last cycle
  wire take = CE_I && START_I && !BUSY_O;  // request accepted
  // keep operands so the answer can be tied to its cause
  always @(posedge CLOCK_I) begin
    d_q <= DEST_I[7:0];
    s_q <= SOURCE_REGISTER_I[7:0];
  end
  default clocking cb @(posedge CLOCK_I);
  endclocking
  default disable iff (RST_I);
  // ---------------------------------------------
  // assertions
  // ---------------------------------------------
  chk_quick_answer: assert property (
    take && OP_I != `OP_UNSIGNED_DIVIDE |=> DONE_O)
    else $error("answer missing one cycle after request");
  chk_div_busy: assert property (
    take && OP_I == `OP_UNSIGNED_DIVIDE |=> BUSY_O [*8])
    else $error("busy dropped during divide");
  chk_div_done: assert property (
    (take && OP_I == `OP_UNSIGNED_DIVIDE) ##1 CE_I [*8] ##1 CE_I
    |=> DONE_O)
    else $error("divide answer not on time");
  chk_compare_quiet: assert property (
    take && OP_I == `OP_COMPARE |=> DONE_O && !WRITE_O)
    else $error("compare wrote a register");
  chk_diff_imm: assert property (
    take && OP_I == `OP_DIFF && IMM_I |=> ILLEGAL_O && !WRITE_O)
    else $error("immediate difference accepted");
  chk_word_imm: assert property (
    take && (OP_I == `OP_SUM || OP_I == `OP_COMPARE) && WORD_I && IMM_I
    |=> ILLEGAL_O && !WRITE_O)
    else $error("word immediate form accepted");
  chk_step_range: assert property (
    take && (OP_I == `OP_WORD_SMALL_SUM || OP_I == `OP_WORD_SMALL_DIFFERENCE)
    && IMM_DATA_I != 16'h0001 && IMM_DATA_I != 16'h0002 |=> ILLEGAL_O)
    else $error("small word step outside 1 and 2 accepted");
  chk_refused_flags: assert property (
    ILLEGAL_O |-> $stable(CONDITION_FLAGS_O) && !WRITE_O)
    else $error("refused form changed flags");
  chk_not_bits: assert property (
    take && OP_I == `OP_NOT |=> RESULT_O[7:0] == ~d_q)
    else $error("ones complement wrong");
  chk_neg_value: assert property (
    take && OP_I == `OP_ARITH_COMPLEMENT |=> RESULT_O[7:0] == 8'h00 - d_q)
    else $error("arithmetic complement wrong");
  chk_rotate_wrap: assert property (
    take && OP_I == `OP_ROTATE_LEFT |=> RESULT_O[7:0] == {d_q[6:0], d_q[7]}
    && CONDITION_FLAGS_O[0] == d_q[7])
    else $error("rotate left wrong");
  chk_mul_product: assert property (
    take && OP_I == `OP_UNSIGNED_MULTIPLY |=> RESULT_O == d_q * s_q)
    else $error("product wrong");
  // main scenarios seen
  cov_divide: cover property (take && OP_I == `OP_UNSIGNED_DIVIDE ##10 DONE_O);
  cov_refused: cover property (DONE_O && ILLEGAL_O);
  cov_carry_rot: cover property (take && OP_I == `OP_ROTATE_LEFT_VIA_CARRY);
endmodule

// ===== operand_file_model.sv
// destination and source registers of the decoder side
module operand_file_model (
  // clock
  input wire logic clk_i,
  // loading by the bench
  input wire logic load_i,
  input wire logic load_sel_i,
  input wire logic [15:0] load_val_i,
  // write back from the unit
  input wire logic write_i,
  input wire logic [15:0] result_i,
  // operands to the unit
  output logic [15:0] dest_o,
  output logic [15:0] source_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // write back wins over a load of the destination
  always @(posedge clk_i) begin
    if (write_i)
      dest_o <= result_i;
    else if (load_i && !load_sel_i)
      dest_o <= load_val_i;
    if (load_i && load_sel_i)
      source_o <= load_val_i;
  end
endmodule

// ===== cpu_arith_logic_shift_unit_bench.sv
`include "alu_defines.vh"
module cpu_arith_logic_shift_unit_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int DIV_STEPS = 8;
  // ---------------------------------------------
  // signals
  // ---------------------------------------------
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic start = 1'b0;
  logic word = 1'b0;
  logic imm = 1'b0;
  logic [4:0] op = 5'h00;
  logic [15:0] imm_data = 16'h0000;
  logic ld = 1'b0;  // operand load strobe
  logic ld_sel = 1'b0;  // 0 destination, 1 source
  logic [15:0] ld_val = 16'h0000;
  wire [15:0] rd_val, rs_val, result;
  wire busy, done, write, word_o, illegal;
  wire [3:0] flags;
  logic [3:0] fl = 4'h0;  // expected flags
  logic [3:0] kn = 4'hf;  // flags with a defined value
  logic [3:0] nf;
  logic [15:0] e_res, cur_d;
  logic e_ill, e_wr, e_wd;
  logic [31:0] seed = 32'h0000003d;
  int la, lb, num_errors = 0, compares = 0;
  cpu_arith_logic_shift_unit #(.DIV_STEPS(DIV_STEPS))
  i_cpu_arith_logic_shift_unit (.CLOCK_I(clk), .RST_I(rst), .CE_I(1'b1),
    .START_I(start), .OP_I(op), .WORD_I(word), .IMM_I(imm),
    .DEST_I(rd_val), .SOURCE_REGISTER_I(rs_val), .IMM_DATA_I(imm_data),
    .BUSY_O(busy), .DONE_O(done), .WRITE_O(write), .WORD_O(word_o),
    .ILLEGAL_O(illegal), .RESULT_O(result), .CONDITION_FLAGS_O(flags));
  operand_file_model i_operand_file_model (.clk_i(clk), .load_i(ld),
    .load_sel_i(ld_sel), .load_val_i(ld_val), .write_i(write),
    .result_i(result), .dest_o(rd_val), .source_o(rs_val));
  // ---------------------------------------------
  // helpers
  // ---------------------------------------------
  initial begin
    forever #10 clk = ~clk;
  end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic stop_test();
    $display("num_errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic check_res(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic check_fl(input logic [3:0] got, input logic [3:0] exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic check_bit(input logic got, input logic exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // two's complement sum or difference; a byte rides in the top byte
  task automatic arith(input logic [15:0] x, y, input logic sb, ci, w);
    logic [16:0] xs, ys, t;
    xs = w ? {1'b0, x} : {1'b0, x[7:0], 8'h00};
    ys = w ? {1'b0, y} : {1'b0, y[7:0], 8'h00};
    t = sb ? xs - ys - (17'(ci) << (w ? 0 : 8)) :
      xs + ys + (17'(ci) << (w ? 0 : 8));
    nf = {t[15], t[15:0] == 16'h0000, (sb ? xs[15] != ys[15] :
      xs[15] == ys[15]) && t[15] != xs[15], t[16]};
    e_res = w ? t[15:0] : {cur_d[15:8], t[15:8]};
  endtask
  // expected answer and flag update of one request
  task automatic model(input logic [4:0] o, input logic w, im,
    input logic [15:0] d, s, iv);
    logic [15:0] b;
    logic [7:0] r;
    logic [3:0] def, unk;
    logic cc, vv;
    int v;
    b = im ? iv : s;
    cur_d = d;
    {def, unk, e_ill, e_wr, r, cc, vv} = {8'hf0, 2'b01, 10'h000};
    e_wd = w && (o < 2 || o == 12) || o inside {6, 7, 10, 11};
    case (o)
      `OP_SUM: if (im && w) e_ill = 1; else arith(d, b, 0, 0, w);
      `OP_DIFF: if (im) e_ill = 1; else arith(d, s, 1, 0, w);
      `OP_COMPARE: if (im && w) e_ill = 1; else arith(d, b, 1, 0, w);
      `OP_SUM_WITH_CARRY: arith(d, b, 0, fl[0], 0);
      `OP_DIFFERENCE_WITH_BORROW: arith(d, b, 1, fl[0], 0);
      `OP_PLUS_ONE: arith(d, 16'h0001, 0, 0, 0);
      `OP_MINUS_ONE: arith(d, 16'h0001, 1, 0, 0);
      `OP_ARITH_COMPLEMENT: arith(16'h0000, d, 1, 0, 0);
      `OP_WORD_SMALL_SUM, `OP_WORD_SMALL_DIFFERENCE: begin
        e_ill = iv != 16'h0001 && iv != 16'h0002;
        e_res = o[0] ? d - iv : d + iv;
        def = 4'h0;
      end
      `OP_DECIMAL_FIX_AFTER_SUM, `OP_DECIMAL_FIX_AFTER_DIFFERENCE: begin
        v = o[0] ? la - lb : la + lb;
        nf[0] = v < 0 || v > 99;
        v = (v + 100) % 100;
        e_res = {d[15:8], 4'(v / 10), 4'(v % 10)};
        {nf[3:2], def} = {e_res[7], e_res[7:0] == 8'h00, 4'hd};
      end
      `OP_UNSIGNED_MULTIPLY: begin
        e_res = d[7:0] * s[7:0];
        def = 4'h0;
      end
      `OP_UNSIGNED_DIVIDE: begin
        e_res = {8'(d % s[7:0]), 8'(d / s[7:0])};
        nf = {e_res[7], e_res[7:0] == 8'h00, 2'b00};
        def = 4'hc;
      end
      `OP_AND: r = d[7:0] & b[7:0];
      `OP_OR: r = d[7:0] | b[7:0];
      `OP_XOR: r = d[7:0] ^ b[7:0];
      `OP_NOT: r = ~d[7:0];
      `OP_ARITH_LEFT_SHIFT: {cc, r, vv} = {d[7:0], 1'b0, d[7] ^ d[6]};
      `OP_ARITH_RIGHT_SHIFT: {r, cc} = {d[7], d[7:0]};
      `OP_LOGIC_LEFT_SHIFT: {cc, r} = {d[7:0], 1'b0};
      `OP_LOGIC_RIGHT_SHIFT: {r, cc} = {1'b0, d[7:0]};
      `OP_ROTATE_LEFT: {cc, r} = {d[7:0], d[7]};
      `OP_ROTATE_RIGHT: {r, cc} = {d[0], d[7:0]};
      `OP_ROTATE_LEFT_VIA_CARRY: {cc, r} = {d[7:0], fl[0]};
      `OP_ROTATE_RIGHT_VIA_CARRY: {r, cc} = {fl[0], d[7:0]};
      default: e_ill = 1;
    endcase
    // byte logic and shift results
    if (o >= `OP_AND && o <= `OP_ROTATE_RIGHT_VIA_CARRY) begin
      e_res = {d[15:8], r};
      nf = {r[7], r == 8'h00, vv, cc};
    end
    if (o >= `OP_AND && o <= `OP_NOT || o == `OP_PLUS_ONE ||
      o == `OP_MINUS_ONE)
      def = 4'he;
    if (e_ill || o == `OP_COMPARE)
      e_wr = 0;
    if (e_ill)
      {def, unk} = 8'h00;
    fl = (nf & def) | (fl & ~def);
    kn = (kn & ~def & ~unk) | def;
  endtask
  // load operands, issue one request and check the answer
  task automatic run_op(input logic [4:0] o, input logic w, im,
    input logic [15:0] a, b, iv);
    int n;
    @(posedge clk);
    {ld, ld_sel, ld_val} <= {2'b10, a};
    @(posedge clk);
    {ld_sel, ld_val} <= {1'b1, b};
    @(posedge clk);
    {ld, start, op, word, imm, imm_data} <= {2'b01, o, w, im, iv};
    model(o, w, im, a, b, iv);
    @(posedge clk);
    start <= 1'b0;
    #1;
    for (n = 0; n < 20 && done !== 1'b1; n++) begin
      @(posedge clk);
      #1;
    end
    if (n == 20) begin
      num_errors++;
      stop_test();
    end
    check_bit(illegal, e_ill);
    check_bit(write, e_wr);
    check_bit(word_o, e_wd);
    if (e_wr) check_res(result, e_res);
    check_fl(flags & kn, fl & kn);
    @(posedge clk);
    #1;
    check_res(rd_val, e_wr ? e_res : a);
  endtask
  // ---------------------------------------------
  // main sequence
  // ---------------------------------------------
  initial begin
    logic [31:0] a, b, iv, r;
    logic w, m;
    int x, y;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    check_fl(flags, 4'h0);
    // every code but the two decimal fixes, two unused ones too, with random operands
    for (int i = 0; i < 28; i++) begin
      for (int k = 0; k < 6 && i != 8 && i != 9; k++) begin
        {a, b, iv, r} = {rnd(), rnd(), rnd(), rnd()};
        {w, m} = (i <= 1 || i == 12) ? r[1:0] : {1'b0, r[0]};
        if (i == 6 || i == 7) {w, m, iv} = {2'b11, r % 3 + 1};
        if (i == 10 || i == 11) m = 1'b0;
        if (i == 11) b[7:0] = b[7:0] | 8'h01;
        if (i == 11) a[15:8] = a[15:8] % b[7:0];
        run_op(5'(i), w, m, a[15:0], b[15:0], iv[15:0]);
      end
    end
    // decimal fix after a sum and after a difference of packed digits
    repeat (4) begin
      {x, y} = {rnd() % 100, rnd() % 100};
      for (int k = 0; k < 2; k++) begin
        {la, lb} = {x, y};
        run_op(k ? `OP_DIFF : `OP_SUM, 0, 0, {8'h00, 4'(x / 10),
          4'(x % 10)}, {8'h00, 4'(y / 10), 4'(y % 10)}, 0);
        run_op(5'h08 + 5'(k), 0, 0, e_res, 0, 0);
      end
    end
    stop_test();
  end
endmodule
bind cpu_arith_logic_shift_unit alu_checker #(.DIV_STEPS(DIV_STEPS)) i_chk (
  .CLOCK_I(CLOCK_I), .RST_I(RST_I), .CE_I(CE_I), .START_I(START_I),
  .OP_I(OP_I), .WORD_I(WORD_I), .IMM_I(IMM_I), .DEST_I(DEST_I),
  .SOURCE_REGISTER_I(SOURCE_REGISTER_I), .IMM_DATA_I(IMM_DATA_I),
  .BUSY_O(BUSY_O), .DONE_O(DONE_O), .WRITE_O(WRITE_O),
  .ILLEGAL_O(ILLEGAL_O), .RESULT_O(RESULT_O),
  .CONDITION_FLAGS_O(CONDITION_FLAGS_O));
